// [rtl/gpio_port12_defines.svh]
// Purpose: Offsets, field positions, reset values for the port 1/2 block
// Assumes: Avalon-MM byte addresses, one 32-bit word per register
// Notes: Data sits in bits 7:0, upper bits read as zero
`ifndef GPIO_PORT12_DEFINES_SVH
`define GPIO_PORT12_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_PIN_FUNCTION_SELECT 5'h00
`define OFS_PORT1_DIRECTION 5'h04
`define OFS_PORT1_OUTPUT_DATA 5'h08
`define OFS_PORT1_PULLUP_ENABLE 5'h0C
`define OFS_PORT2_DIRECTION 5'h10
`define OFS_PORT2_OUTPUT_DATA 5'h14

// ****************************************
// Field positions in pin_function_select
// ****************************************
`define FSEL_EXT_INT3_BIT 7
`define FSEL_EXT_INT2_BIT 6
`define FSEL_EXT_INT1_BIT 5
`define FSEL_EXT_INT0_BIT 4
`define FSEL_TXD_BIT 1
`define FSEL_TIMER_OUT_BIT 0

// ****************************************
// Masks and reset values
// ****************************************
`define P1_IMPL_MASK 8'hF7
`define P1_RSVD_ONES 8'h08
`define P2_IMPL_MASK 8'h07
`define P2_RSVD_ONES 8'hF8
`define FSEL_IMPL_MASK 8'hF3
`define FSEL_RSVD_ONES 8'h0C
`define REG_RESET 8'h00
`define WO_READ_VALUE 8'hFF
`define LINE_IDLE 1'b1

`endif

// [rtl/gpio_port12_pkg.sv]
// Purpose: Types shared by the port 1/2 block
// Assumes: Nothing beyond the defines header
// Notes: Constants live in the defines header
package gpio_port12_pkg;
  typedef logic [7:0] reg8_t;
  typedef logic [4:0] bus_addr_t;
  typedef enum {BUS_IDLE, BUS_DONE} bus_st_e;
endpackage

// [rtl/gpio_port12_ctrl.sv]
// Purpose: Port 1 and port 2 pin control with Avalon-MM registers
// Assumes: Peripheral signals are on i_mclk; pins are asynchronous
// Notes: Every pin output is registered, so pins follow registers one cycle later
//
// Functional notes
// - Port 1 general pin: direction 1 drives output, 0 makes input.
// - Port 1 direction is write-only per bit, resets 0, bit 3 reserved.
// - Port 1 data and pull-up bit 3 always read as 1.
// - Port 1 data register holds output values, resets to 0.
// - Data read returns stored bit where direction is output.
// - Data read returns pin level where direction is input.
// - Pull-up acts only on input pins, never on driven pins.
// - Pull-up bit 1 turns pull-up on, 0 off, resets 0.
// - Selected pin 7 feeds interrupt 3 and timer trigger, direction ignored.
// - Pins 6..4 feed interrupts 2..0, pin 0 outputs timer; pins 2,1 plain.
// - Port 2 function select and serial settings beat direction bits.
// - Port 2 direction bits 2..0 write-only, reset 0, 1 output.
// - Function select: 7..4 interrupts, 1 transmit, 0 timer; reset 0.
// - Port 2 data read: output bits stored value, input bits pins.
`timescale 1ns/100ps
`include "gpio_port12_defines.svh"

module gpio_port12_ctrl
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire gpio_port12_pkg::bus_addr_t i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [7:0] i_p1_pin,
  output logic [7:0] o_p1_out,
  output logic [7:0] o_p1_oe,
  output logic [7:0] o_p1_pullup,
  input wire logic [2:0] i_p2_pin,
  output logic [2:0] o_p2_out,
  output logic [2:0] o_p2_oe,
  input wire logic i_timer_waveform_output,
  input wire logic i_serial_txd,
  input wire logic i_serial_rx_enable,
  input wire logic i_serial_sck_in_enable,
  input wire logic i_serial_sck_out_enable,
  input wire logic i_serial_sck_out,
  output logic [3:0] o_ext_interrupt_line,
  output logic o_timer_trigger_input,
  output logic o_serial_rxd,
  output logic o_serial_sck_in
);
  import gpio_port12_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  reg8_t fsel_q;
  reg8_t p1_dir_q;
  reg8_t p1_data_q;
  reg8_t p1_pu_q;
  reg8_t p2_dir_q;
  reg8_t p2_data_q;
  reg8_t p1_s1_q;
  reg8_t p1_s2_q;
  logic [2:0] p2_s1_q;
  logic [2:0] p2_s2_q;
  bus_st_e bus_st_q;
  bus_st_e bus_st_d;

  // ****************************************
  // Bus decode
  // ****************************************
  wire req = i_avs_read | i_avs_write;
  wire take = req && (bus_st_q == BUS_IDLE);
  wire wr_en = i_avs_write && (bus_st_q == BUS_DONE) && i_avs_byteenable[0];
  wire hit_fsel = (i_avs_address == `OFS_PIN_FUNCTION_SELECT);
  wire hit_p1_dir = (i_avs_address == `OFS_PORT1_DIRECTION);
  wire hit_p1_dat = (i_avs_address == `OFS_PORT1_OUTPUT_DATA);
  wire hit_p1_pu = (i_avs_address == `OFS_PORT1_PULLUP_ENABLE);
  wire hit_p2_dir = (i_avs_address == `OFS_PORT2_DIRECTION);
  wire hit_p2_dat = (i_avs_address == `OFS_PORT2_OUTPUT_DATA);
  wire reg8_t wbyte = i_avs_writedata[7:0];

  // Mixed reads: stored value where output, synchronised pin where input
  wire reg8_t p1_rd = (p1_data_q & p1_dir_q) | (p1_s2_q & ~p1_dir_q);
  wire reg8_t p1_dat_rd = (p1_rd & `P1_IMPL_MASK) | `P1_RSVD_ONES;
  wire reg8_t p1_pu_rd = (p1_pu_q & `P1_IMPL_MASK) | `P1_RSVD_ONES;
  wire [2:0] p2_rd = (p2_data_q[2:0] & p2_dir_q[2:0]) | (p2_s2_q & ~p2_dir_q[2:0]);
  wire reg8_t p2_dat_rd = {5'h1F, p2_rd};
  wire reg8_t fsel_rd = (fsel_q & `FSEL_IMPL_MASK) | `FSEL_RSVD_ONES;

  // Write-only direction registers give a fixed pattern, not their contents
  wire reg8_t rd_mux =
    hit_fsel ? fsel_rd :
    (hit_p1_dir || hit_p2_dir) ? `WO_READ_VALUE :
    hit_p1_dat ? p1_dat_rd :
    hit_p1_pu ? p1_pu_rd :
    hit_p2_dat ? p2_dat_rd : `REG_RESET;

  always_comb
  begin
    unique case (bus_st_q)
      BUS_IDLE: bus_st_d = req ? BUS_DONE : BUS_IDLE;
      BUS_DONE: bus_st_d = BUS_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      bus_st_q <= BUS_IDLE;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      bus_st_q <= bus_st_d;
      o_avs_waitrequest <= !take;
      if (take && i_avs_read)
        o_avs_readdata <= {24'h00_0000, rd_mux};
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      fsel_q <= `REG_RESET;
      p1_dir_q <= `REG_RESET;
      p1_data_q <= `REG_RESET;
      p1_pu_q <= `REG_RESET;
      p2_dir_q <= `REG_RESET;
      p2_data_q <= `REG_RESET;
    end
    else if (wr_en)
    begin
      if (hit_fsel)
        fsel_q <= wbyte & `FSEL_IMPL_MASK;
      if (hit_p1_dir)
        p1_dir_q <= wbyte & `P1_IMPL_MASK;
      if (hit_p1_dat)
        p1_data_q <= wbyte & `P1_IMPL_MASK;
      if (hit_p1_pu)
        p1_pu_q <= wbyte & `P1_IMPL_MASK;
      if (hit_p2_dir)
        p2_dir_q <= wbyte & `P2_IMPL_MASK;
      if (hit_p2_dat)
        p2_data_q <= wbyte & `P2_IMPL_MASK;
    end
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      p1_s1_q <= 8'h00;
      p1_s2_q <= 8'h00;
      p2_s1_q <= 3'h0;
      p2_s2_q <= 3'h0;
    end
    else
    begin
      p1_s1_q <= i_p1_pin;
      p1_s2_q <= p1_s1_q;
      p2_s1_q <= i_p2_pin;
      p2_s2_q <= p2_s1_q;
    end
  end

  // ****************************************
  // Port 1 pin steering
  // ****************************************
  // Alternate-input select per pin; bit 3 has no pin, its driver stays off
  wire reg8_t p1_alt_in = {fsel_q[7:4], 4'h0};
  wire p1_alt_out0 = fsel_q[`FSEL_TIMER_OUT_BIT];
  reg8_t p1_oe_d;
  reg8_t p1_out_d;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_p1
      if (gi == 3)
      begin : g_rsvd
        assign p1_oe_d[gi] = 1'b0;
        assign p1_out_d[gi] = 1'b0;
      end
      else if (gi == 0)
      begin : g_tmo
        assign p1_oe_d[gi] = p1_alt_out0 | p1_dir_q[gi];
        assign p1_out_d[gi] = p1_alt_out0 ? i_timer_waveform_output : p1_data_q[gi];
      end
      else
      begin : g_gen
        assign p1_oe_d[gi] = !p1_alt_in[gi] && p1_dir_q[gi];
        assign p1_out_d[gi] = p1_data_q[gi];
      end
    end
  endgenerate

  // Pull-up gated by the real driver state so a timer output never fights it
  wire reg8_t p1_pu_d = p1_pu_q & ~p1_oe_d & `P1_IMPL_MASK;

  // Unselected interrupt and trigger lines rest at their idle level
  wire [3:0] irq_d;
  assign irq_d[3] = fsel_q[`FSEL_EXT_INT3_BIT] ? p1_s2_q[7] : `LINE_IDLE;
  assign irq_d[2] = fsel_q[`FSEL_EXT_INT2_BIT] ? p1_s2_q[6] : `LINE_IDLE;
  assign irq_d[1] = fsel_q[`FSEL_EXT_INT1_BIT] ? p1_s2_q[5] : `LINE_IDLE;
  assign irq_d[0] = fsel_q[`FSEL_EXT_INT0_BIT] ? p1_s2_q[4] : `LINE_IDLE;
  wire trg_d = fsel_q[`FSEL_EXT_INT3_BIT] ? p1_s2_q[7] : `LINE_IDLE;

  // ****************************************
  // Port 2 pin steering
  // ****************************************
  wire txd_sel = fsel_q[`FSEL_TXD_BIT];
  wire sck_drv = !i_serial_sck_in_enable && i_serial_sck_out_enable;
  wire [2:0] p2_oe_d;
  wire [2:0] p2_out_d;
  assign p2_oe_d[2] = txd_sel | p2_dir_q[2];
  assign p2_out_d[2] = txd_sel ? i_serial_txd : p2_data_q[2];
  assign p2_oe_d[1] = !i_serial_rx_enable && p2_dir_q[1];
  assign p2_out_d[1] = p2_data_q[1];
  assign p2_oe_d[0] = sck_drv || (!i_serial_sck_in_enable && p2_dir_q[0]);
  assign p2_out_d[0] = sck_drv ? i_serial_sck_out : p2_data_q[0];
  wire rxd_d = i_serial_rx_enable ? p2_s2_q[1] : `LINE_IDLE;
  wire sck_in_d = i_serial_sck_in_enable ? p2_s2_q[0] : `LINE_IDLE;

  // ****************************************
  // Output registers
  // ****************************************
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      o_p1_out <= 8'h00;
      o_p1_oe <= 8'h00;
      o_p1_pullup <= 8'h00;
      o_p2_out <= 3'h0;
      o_p2_oe <= 3'h0;
      o_ext_interrupt_line <= 4'hF;
      o_timer_trigger_input <= 1'b1;
      o_serial_rxd <= 1'b1;
      o_serial_sck_in <= 1'b1;
    end
    else
    begin
      o_p1_out <= p1_out_d;
      o_p1_oe <= p1_oe_d;
      o_p1_pullup <= p1_pu_d;
      o_p2_out <= p2_out_d;
      o_p2_oe <= p2_oe_d;
      o_ext_interrupt_line <= irq_d;
      o_timer_trigger_input <= trg_d;
      o_serial_rxd <= rxd_d;
      o_serial_sck_in <= sck_in_d;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  wire ack_rd = !o_avs_waitrequest && i_avs_read;

  a_reset_clears: assert property ($past(i_rst) |->
    (p1_dir_q == 8'h00) && (p1_data_q == 8'h00) && (p1_pu_q == 8'h00) && (p2_dir_q == 8'h00)
    && (fsel_q == 8'h00) && (o_p1_oe == 8'h00))
    else $error("registers not cleared by reset");

  a_p1_gpio_drive: assert property (!fsel_q[4] |=>
    (o_p1_oe[4] == $past(p1_dir_q[4])) && (o_p1_out[4] == $past(p1_data_q[4])))
    else $error("port 1 pin 4 not following direction and data");

  a_p1_plain_pins: assert property (o_p1_oe[2:1] == $past(p1_dir_q[2:1]))
    else $error("port 1 pins 2 and 1 not following direction");

  a_rsvd_read_one: assert property ((ack_rd && (hit_p1_dat || hit_p1_pu)) |-> o_avs_readdata[3])
    else $error("reserved bit 3 did not read as one");

  a_read_stored: assert property ((ack_rd && hit_p1_dat) |->
    (((o_avs_readdata[7:0] ^ p1_data_q) & p1_dir_q) == 8'h00))
    else $error("output bits did not read stored value");

  a_read_pin: assert property ((ack_rd && hit_p1_dat) |->
    (((o_avs_readdata[7:0] ^ $past(p1_s2_q)) & ~p1_dir_q & `P1_IMPL_MASK) == 8'h00))
    else $error("input bits did not read synchronised pins");

  a_p2_read_mix: assert property ((ack_rd && hit_p2_dat) |->
    (o_avs_readdata[2:0] == (($past(p2_s2_q) & ~p2_dir_q[2:0]) | (p2_data_q[2:0] & p2_dir_q[2:0]))))
    else $error("port 2 data read mismatch");

  a_pullup_gated: assert property ((o_p1_pullup & o_p1_oe) == 8'h00)
    else $error("pull-up on while pin driven");

  a_pullup_on: assert property ((p1_pu_q[5] && !p1_dir_q[5]) |=> o_p1_pullup[5])
    else $error("pull-up did not turn on");

  a_ext_interrupt_line_3_route: assert property (fsel_q[7] |=>
    !o_p1_oe[7] && (o_timer_trigger_input == $past(p1_s2_q[7])) && (o_ext_interrupt_line[3] == o_timer_trigger_input))
    else $error("pin 7 alternate input misrouted");

  a_timer_out: assert property (fsel_q[0] |=> o_p1_oe[0] && (o_p1_out[0] == $past(i_timer_waveform_output)))
    else $error("timer waveform not on pin 0");

  a_irq_inputs: assert property (fsel_q[6] |=> !o_p1_oe[6] && (o_ext_interrupt_line[2] == $past(p1_s2_q[6])))
    else $error("pin 6 interrupt input misrouted");

  a_txd_priority: assert property (fsel_q[1] |=> o_p2_oe[2] && (o_p2_out[2] == $past(i_serial_txd)))
    else $error("transmit select did not override direction");

  a_rx_priority: assert property (i_serial_rx_enable |=> !o_p2_oe[1])
    else $error("receive pin still driven");

  a_rxd_route: assert property (i_serial_rx_enable |=> (o_serial_rxd == $past(p2_s2_q[1])))
    else $error("receive line not fed from pin 1 of port 2");

  a_sck_in_wins: assert property (i_serial_sck_in_enable |=>
    !o_p2_oe[0] && (o_serial_sck_in == $past(p2_s2_q[0])))
    else $error("serial clock input pin still driven or misrouted");

  a_p2_gpio_drive: assert property (!fsel_q[1] |=>
    (o_p2_oe[2] == $past(p2_dir_q[2])) && (o_p2_out[2] == $past(p2_data_q[2])))
    else $error("port 2 pin 2 not following direction and data");

  a_bus_answer: assert property ((req && o_avs_waitrequest) |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus answer not one cycle");

  c_write_then_read: cover property (wr_en && hit_p1_dat ##[1:20] ack_rd && hit_p1_dat);
  c_timer_pin: cover property (fsel_q[0] ##1 o_p1_oe[0]);
  c_irq_line: cover property (fsel_q[4] ##[1:10] !o_ext_interrupt_line[0]);
  c_txd_pin: cover property (fsel_q[1] ##1 o_p2_oe[2]);

endmodule // gpio_port12_ctrl

// [tb/tb.sv]
// Purpose: Self-checking bench for the port 1/2 pin control block
// Assumes: Master waits on waitrequest and assumes no fixed latency
// Notes: Random stimulus from a fixed seed, corner passes first
`timescale 1ns/100ps
`include "gpio_port12_defines.svh"

module tb;
  import gpio_port12_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  bus_addr_t adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] be = 4'hF;
  reg8_t p1 = 8'hA5;
  logic [2:0] p2 = 3'h5;
  logic [5:0] misc = 6'h00;
  logic [31:0] rdat;
  logic wreq;
  reg8_t p1_out, p1_oe, p1_pu;
  logic [2:0] p2_out, p2_oe;
  logic [3:0] ext;
  logic trg, rxd, sckin;
  int seed = 53;
  int bad_count = 0;
  int checked = 0;
  int cyc = 0;
  reg8_t fs, d1, o1, pu, oe1;
  logic [2:0] d2, o2, oe2;
  logic [31:0] q;

  gpio_port12_ctrl u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(be), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .i_p1_pin(p1), .o_p1_out(p1_out), .o_p1_oe(p1_oe), .o_p1_pullup(p1_pu),
    .i_p2_pin(p2), .o_p2_out(p2_out), .o_p2_oe(p2_oe), .i_timer_waveform_output(misc[5]),
    .i_serial_txd(misc[4]), .i_serial_rx_enable(misc[3]), .i_serial_sck_in_enable(misc[2]),
    .i_serial_sck_out_enable(misc[1]), .i_serial_sck_out(misc[0]), .o_ext_interrupt_line(ext),
    .o_timer_trigger_input(trg), .o_serial_rxd(rxd), .o_serial_sck_in(sckin));

  // ****************************************
  // Clock, timeout, helpers
  // ****************************************
  initial
  begin
    forever #2 i_mclk = ~i_mclk;
  end

  // Whole run needs about 1600 cycles
  always @(posedge i_mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Request held until the rising edge that samples waitrequest low
  task automatic bus(input logic w, input bus_addr_t a, input reg8_t d, input logic [3:0] b,
                     output logic [31:0] r);
    @(posedge i_mclk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= {24'h0, d};
    be <= b;
    do @(posedge i_mclk); while (wreq !== 1'b0);
    r = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  function automatic reg8_t mix(reg8_t dir, reg8_t dat, reg8_t pin);
    return (dir & dat) | (~dir & pin);
  endfunction

  function automatic reg8_t e_oe1(reg8_t f, reg8_t d);
    return (d & `P1_IMPL_MASK & ~{f[7:4], 4'h0}) | {7'h0, f[0]};
  endfunction

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (4) @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_mclk);
    @(negedge i_mclk);
    chk(p1_oe, 8'h00);
    chk(p1_pu, 8'h00);
    chk({ext, trg, rxd, sckin, p2_oe}, {4'hF, 3'h7, 3'h0});
    bus(1'b0, `OFS_PIN_FUNCTION_SELECT, 8'h00, 4'hF, q);
    chk(q, 32'h0C);
    bus(1'b0, `OFS_PORT1_OUTPUT_DATA, 8'h00, 4'hF, q);
    chk(q, {24'h0, (8'hA5 & `P1_IMPL_MASK) | `P1_RSVD_ONES});
    bus(1'b0, `OFS_PORT1_PULLUP_ENABLE, 8'h00, 4'hF, q);
    chk(q, 32'h08);
    bus(1'b0, `OFS_PORT1_DIRECTION, 8'h00, 4'hF, q);
    chk(q, 32'hFF);
    for (int i = 0; i < 40; i++)
    begin
      fs = $random(seed);
      d1 = $random(seed);
      o1 = $random(seed);
      pu = $random(seed);
      {d2, o2} = $random(seed);
      if (i == 0)
      begin
        fs = 8'h00;
        d1 = 8'h00;
      end
      if (i == 1)
      begin
        fs = 8'hF3;
        d1 = 8'hFF;
        pu = 8'hFF;
      end
      misc <= $random(seed);
      p1 <= $random(seed);
      p2 <= $random(seed);
      bus(1'b1, `OFS_PIN_FUNCTION_SELECT, fs, 4'hF, q);
      bus(1'b1, `OFS_PORT1_DIRECTION, d1, 4'hF, q);
      bus(1'b1, `OFS_PORT1_OUTPUT_DATA, o1, 4'hF, q);
      bus(1'b1, `OFS_PORT1_PULLUP_ENABLE, pu, 4'hF, q);
      bus(1'b1, `OFS_PORT2_DIRECTION, {5'h0, d2}, 4'hF, q);
      bus(1'b1, `OFS_PORT2_OUTPUT_DATA, {5'h0, o2}, 4'hF, q);
      repeat (8) @(posedge i_mclk);
      @(negedge i_mclk);
      oe1 = e_oe1(fs, d1);
      oe2 = {fs[1] | d2[2], ~misc[3] & d2[1], ~misc[2] & (misc[1] | d2[0])};
      chk(p1_oe, oe1);
      chk(p1_out & p1_oe, {o1[7:1], fs[0] ? misc[5] : o1[0]} & oe1);
      chk(p1_pu, pu & `P1_IMPL_MASK & ~oe1);
      chk({ext, trg}, {p1[7:4] | ~fs[7:4], p1[7] | ~fs[7]});
      chk(p2_oe, oe2);
      chk(p2_out & oe2, {fs[1] ? misc[4] : o2[2], o2[1], misc[1] ? misc[0] : o2[0]} & oe2);
      chk({rxd, sckin}, {p2[1] | ~misc[3], p2[0] | ~misc[2]});
      bus(1'b0, `OFS_PORT1_OUTPUT_DATA, 8'h00, 4'hF, q);
      chk(q, {24'h0, mix(d1, o1, p1) & `P1_IMPL_MASK | `P1_RSVD_ONES});
      bus(1'b0, `OFS_PORT2_OUTPUT_DATA, 8'h00, 4'hF, q);
      chk(q, {24'h0, mix({5'h0, d2}, {5'h0, o2}, {5'h0, p2}) | `P2_RSVD_ONES});
      bus(1'b0, `OFS_PIN_FUNCTION_SELECT, 8'h00, 4'hF, q);
      chk(q, {24'h0, fs & `FSEL_IMPL_MASK | `FSEL_RSVD_ONES});
      bus(1'b0, `OFS_PORT1_PULLUP_ENABLE, 8'h00, 4'hF, q);
      chk(q, {24'h0, pu & `P1_IMPL_MASK | `P1_RSVD_ONES});
    end
    // Lane 0 disabled: store must not happen
    bus(1'b1, `OFS_PORT1_OUTPUT_DATA, ~o1, 4'hE, q);
    bus(1'b0, `OFS_PORT1_OUTPUT_DATA, 8'h00, 4'hF, q);
    chk(q, {24'h0, mix(d1, o1, p1) & `P1_IMPL_MASK | `P1_RSVD_ONES});
    bus(1'b0, 5'h18, 8'h00, 4'hF, q);
    chk(q, 32'h0);
    // Second reset in mid-run
    @(posedge i_mclk);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_mclk);
    @(negedge i_mclk);
    chk({p1_oe, p1_pu}, 16'h0);
    bus(1'b0, `OFS_PORT1_PULLUP_ENABLE, 8'h00, 4'hF, q);
    chk(q, 32'h08);
    final_report();
  end
endmodule // tb
